// >>> hdl/fault_resp_pkg.sv
// Constants, encodings and register map of the low-voltage bus fault response block
// Notes on behaviour
// - With the override bit set, each fault takes its reaction from its response field.
// - With the override bit clear, fields are ignored and the strapped mode decides.
// - Output overvoltage field is bits 1:0; 00 flag, 01 hiccup, 10 latch, 11 flag.
// - Output overvoltage sets status bit 0 and pulls the fault flag low, always.
// - Output undervoltage field is bits 3:2; sets status bit 1, flag low.
// - Input overvoltage field is bits 5:4; sets status bit 2, flag low.
// - Flag-only keeps switching running; no hiccup, no latch-off.
// - Hiccup on overvoltage stops switching, resumes 500 ms after the condition clears.
// - Hiccup on undervoltage stops switching, resumes 500 ms after the condition clears.
// - Latch-off on overvoltage stops switching and never resumes on its own.
// - Latch-off on undervoltage stops switching and keeps it stopped after clearing.
package fault_resp_pkg;
	// Clock and hiccup delay
	localparam int unsigned CLK_FREQ_HZ = 100_000_000;
	localparam int unsigned HICCUP_TIME_MS = 500;
	localparam int unsigned HICCUP_CYCLES_DEF = (CLK_FREQ_HZ / 1000) * HICCUP_TIME_MS;
	localparam int unsigned CNT_W = 26;
	// Fault channels: 0 output overvoltage, 1 output undervoltage, 2 input overvoltage
	localparam int unsigned N_CHAN = 3;
	localparam int unsigned CH_OUT_OV = 0;
	localparam int unsigned CH_OUT_UV = 1;
	localparam int unsigned CH_IN_OV = 2;
	// Synchroniser bit positions
	localparam int unsigned N_SYNC = 7;
	localparam int unsigned SY_PWM_EN = 3;
	localparam int unsigned SY_CHIP_EN = 4;
	localparam int unsigned SY_MODE_LO = 5;
	// Register indexes; byte address is four times the index
	localparam logic [7:0] IDX_GLOBAL = 8'hb0;
	localparam logic [7:0] IDX_RESP = 8'hb7;
	localparam logic [7:0] IDX_STATUS = 8'hd7;
	localparam logic [7:0] IDX_MASK = 8'he0;
	localparam logic [7:0] IDX_STATE = 8'he1;
	// Field positions and reset values
	localparam int unsigned OVR_BIT = 7;
	localparam int unsigned RESP_W = 8;
	localparam logic [7:0] RESP_RST = 8'h00;
	localparam logic [2:0] STATUS_RST = 3'h0;
	localparam logic [2:0] MASK_RST = 3'h0;
	localparam logic OVR_RST = 1'b0;
	localparam logic [2:0] HSIZE_WORD = 3'h2;
	// Response codes
	typedef enum logic [1:0] {
		RESP_FLAG = 2'b00,
		RESP_HICCUP = 2'b01,
		RESP_LATCH = 2'b10,
		RESP_FLAG_ALT = 2'b11
	} resp_t;
	// Channel states
	typedef enum logic [1:0] {
		ST_RUN = 2'b00,
		ST_HICCUP = 2'b01,
		ST_LATCHED = 2'b10
	} chan_state_t;
endpackage : fault_resp_pkg

// >>> hdl/fault_resp_chan.sv
// One fault channel: flag-only, hiccup or latch-off reaction with restart timer
module fault_resp_chan #(
	parameter int unsigned HICCUP_CYCLES = fault_resp_pkg::HICCUP_CYCLES_DEF
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic fault,
	input wire fault_resp_pkg::resp_t resp,
	input wire logic rearm,
	output logic stop,
	output fault_resp_pkg::chan_state_t state
);
	import fault_resp_pkg::*;

	typedef struct packed {
		chan_state_t st;
		logic [CNT_W-1:0] cnt;
	} chan_t;

	localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(HICCUP_CYCLES - 1);

	chan_t q;
	chan_t d;

	// Reaction state machine
	always_comb begin
		d = q;
		unique case (q.st)
			ST_RUN: begin
				if (fault && resp == RESP_HICCUP) begin
					d.st = ST_HICCUP;
					d.cnt = '0;
				end else if (fault && resp == RESP_LATCH) begin
					d.st = ST_LATCHED;
				end
			end
			ST_HICCUP: begin
				if (fault && resp == RESP_LATCH) begin
					d.st = ST_LATCHED;
				end else if (fault) begin
					d.cnt = '0;
				end else if (q.cnt == CNT_LAST) begin
					d.st = ST_RUN;
				end else begin
					d.cnt = q.cnt + 1'b1;
				end
			end
			ST_LATCHED: begin
				if (rearm) begin
					d.st = ST_RUN;
				end
			end
			default: begin
				d.st = ST_RUN;
			end
		endcase
	end

	// State register
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			q <= '{st: ST_RUN, cnt: '0};
		end else begin
			q <= d;
		end
	end

	assign stop = (q.st != ST_RUN);
	assign state = q.st;

	flag_keeps_run_a: assert property (@(posedge clk) disable iff (!resetn)
		(q.st == ST_RUN && (resp == RESP_FLAG || resp == RESP_FLAG_ALT)) |=> (q.st == ST_RUN))
		else $error("flag-only response stopped switching");
	hiccup_stop_a: assert property (@(posedge clk) disable iff (!resetn)
		(q.st == ST_RUN && fault && resp == RESP_HICCUP) |=> (stop && q.cnt == '0))
		else $error("hiccup did not stop switching");
	hiccup_restart_a: assert property (@(posedge clk) disable iff (!resetn)
		(q.st == ST_HICCUP && fault && resp != RESP_LATCH) |=> (q.st == ST_HICCUP && q.cnt == '0))
		else $error("hiccup delay not restarted by fault");
	hiccup_release_a: assert property (@(posedge clk) disable iff (!resetn)
		(q.st == ST_HICCUP && !fault && q.cnt == CNT_LAST) |=> (q.st == ST_RUN && !stop))
		else $error("hiccup did not release at end of delay");
	hiccup_hold_a: assert property (@(posedge clk) disable iff (!resetn)
		(q.st == ST_HICCUP && q.cnt != CNT_LAST) |=> stop)
		else $error("hiccup released early");
	latch_hold_a: assert property (@(posedge clk) disable iff (!resetn)
		(q.st == ST_LATCHED && !rearm) |=> (q.st == ST_LATCHED))
		else $error("latch-off released without enable toggle");
	latch_rearm_a: assert property (@(posedge clk) disable iff (!resetn)
		(q.st == ST_LATCHED && rearm) |=> (q.st == ST_RUN))
		else $error("enable toggle did not clear latch-off");
endmodule : fault_resp_chan

// >>> hdl/lvbus_fault_resp.sv
// Low-voltage bus fault response selector with AHB-Lite register slave
module lvbus_fault_resp #(
	parameter int unsigned HICCUP_CYCLES = fault_resp_pkg::HICCUP_CYCLES_DEF
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic out_ov_det,
	input wire logic out_uv_det,
	input wire logic in_ov_det,
	input wire logic pwm_en,
	input wire logic chip_en,
	input wire logic [1:0] mode_strap,
	output logic fault_flag_n,
	output logic pwm_stop,
	output logic irq
);
	import fault_resp_pkg::*;

	typedef struct packed {
		logic [N_SYNC-1:0] sync1;
		logic [N_SYNC-1:0] sync2;
		logic [1:0] en_prev;
		logic ovr;
		logic [RESP_W-1:0] resp;
		logic [N_CHAN-1:0] status;
		logic [N_CHAN-1:0] mask;
		logic wr_pend;
		logic [7:0] wr_idx;
		logic [31:0] rdata;
		logic flag_n;
		logic stop;
		logic irq;
		logic rdy;
	} top_t;

	top_t q;
	top_t d;

	logic [N_CHAN-1:0] chan_stop;
	logic [N_CHAN-1:0] fault_s;
	resp_t sel_resp [N_CHAN];
	chan_state_t chan_st [N_CHAN];
	logic rearm;
	logic addr_phase;
	logic addr_ok;

	// Synchronised fault levels and enable toggle detection
	assign fault_s = q.sync2[N_CHAN-1:0];
	assign rearm = (q.sync2[SY_CHIP_EN:SY_PWM_EN] != q.en_prev);

	// Bus address phase decode; only the low word index range is mapped
	assign addr_phase = hsel && hready && htrans[1];
	assign addr_ok = (haddr[31:10] == 22'h000000);

	// One reaction channel per fault
	generate
		for (genvar i = 0; i < N_CHAN; i++) begin : g_chan
			// Register field when overridden, strapped mode otherwise
			assign sel_resp[i] = q.ovr ? resp_t'(q.resp[2*i+1:2*i])
				: resp_t'(q.sync2[SY_MODE_LO+1:SY_MODE_LO]);
			fault_resp_chan #(
				.HICCUP_CYCLES(HICCUP_CYCLES)
			) u_chan (
				.clk(clk),
				.resetn(resetn),
				.fault(fault_s[i]),
				.resp(sel_resp[i]),
				.rearm(rearm),
				.stop(chan_stop[i]),
				.state(chan_st[i])
			);
		end
	endgenerate

	// Next state: synchronisers, register writes, status, outputs and read data
	always_comb begin
		logic [N_CHAN-1:0] w1c;
		w1c = '0;
		d = q;
		d.sync1 = {mode_strap, chip_en, pwm_en, in_ov_det, out_uv_det, out_ov_det};
		d.sync2 = q.sync1;
		d.en_prev = q.sync2[SY_CHIP_EN:SY_PWM_EN];
		// Write data phase commits the captured address
		if (q.wr_pend) begin
			case (q.wr_idx)
				IDX_GLOBAL: d.ovr = hwdata[OVR_BIT];
				IDX_RESP: d.resp = hwdata[RESP_W-1:0];
				IDX_STATUS: w1c = hwdata[N_CHAN-1:0];
				IDX_MASK: d.mask = hwdata[N_CHAN-1:0];
				default: ;
			endcase
		end
		d.wr_pend = addr_phase && hwrite && addr_ok && (hsize == HSIZE_WORD);
		d.wr_idx = haddr[9:2];
		// Sticky fault bits; a new fault wins over a clear in the same cycle
		d.status = (q.status & ~w1c) | fault_s;
		d.flag_n = ~|d.status;
		d.irq = |(d.status & d.mask);
		d.stop = |chan_stop;
		d.rdy = 1'b1;
		// Read data built from next values so a write just before is seen
		d.rdata = 32'h0000_0000;
		if (addr_phase && !hwrite && addr_ok) begin
			case (haddr[9:2])
				IDX_GLOBAL: d.rdata[OVR_BIT] = d.ovr;
				IDX_RESP: d.rdata[RESP_W-1:0] = d.resp;
				IDX_STATUS: d.rdata[N_CHAN-1:0] = d.status;
				IDX_MASK: d.rdata[N_CHAN-1:0] = d.mask;
				IDX_STATE: d.rdata[N_CHAN:0] = {q.stop, chan_stop};
				default: ;
			endcase
		end
	end

	// State register
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			q <= '{sync1: '0, sync2: '0, en_prev: '0, ovr: OVR_RST, resp: RESP_RST,
				status: STATUS_RST, mask: MASK_RST, wr_pend: 1'b0, wr_idx: '0,
				rdata: '0, flag_n: 1'b1, stop: 1'b0, irq: 1'b0, rdy: 1'b1};
		end else begin
			q <= d;
		end
	end

	// Outputs straight from flip-flops, except hresp, which is tied to zero
	assign hrdata = q.rdata;
	assign hreadyout = q.rdy;
	assign hresp = 1'b0;
	assign fault_flag_n = q.flag_n;
	assign pwm_stop = q.stop;
	assign irq = q.irq;

	out_ov_status_a: assert property (@(posedge clk) disable iff (!resetn)
		fault_s[CH_OUT_OV] |=> (q.status[CH_OUT_OV] && !fault_flag_n))
		else $error("output overvoltage not flagged");
	out_uv_status_a: assert property (@(posedge clk) disable iff (!resetn)
		fault_s[CH_OUT_UV] |=> (q.status[CH_OUT_UV] && !fault_flag_n))
		else $error("output undervoltage not flagged");
	in_ov_status_a: assert property (@(posedge clk) disable iff (!resetn)
		fault_s[CH_IN_OV] |=> (q.status[CH_IN_OV] && !fault_flag_n))
		else $error("input overvoltage not flagged");
	flag_tracks_a: assert property (@(posedge clk) disable iff (!resetn)
		fault_flag_n == (q.status == '0))
		else $error("fault flag disagrees with status");
	field_select_a: assert property (@(posedge clk) disable iff (!resetn)
		(q.ovr && q.resp[1:0] == RESP_HICCUP && fault_s[CH_OUT_OV] && !rearm
			&& chan_st[CH_OUT_OV] != ST_LATCHED)
		|=> (chan_st[CH_OUT_OV] == ST_HICCUP) ##1 pwm_stop)
		else $error("register field ignored while overridden");
	strap_select_a: assert property (@(posedge clk) disable iff (!resetn)
		(!q.ovr && q.sync2[SY_MODE_LO+1:SY_MODE_LO] == RESP_LATCH && fault_s[CH_IN_OV] && !rearm)
		|=> (chan_st[CH_IN_OV] == ST_LATCHED))
		else $error("strapped mode ignored without override");
	stop_follows_a: assert property (@(posedge clk) disable iff (!resetn)
		(chan_stop == '0) |=> !pwm_stop)
		else $error("switching stopped with no channel stopped");
endmodule : lvbus_fault_resp

// >>> tb/pwm_ctrl_model.sv
// Behavioural switching controller that owns the two enable pins
module pwm_ctrl_model (
	input wire logic clk,
	input wire logic resetn,
	input wire logic toggle_pwm,
	input wire logic toggle_chip,
	output logic pwm_en,
	output logic chip_en
);
	timeunit 1ns;
	timeprecision 1ns;
	// Enables start high; each request cycle flips one pin to restart after latch-off
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pwm_en <= 1'b1;
			chip_en <= 1'b1;
		end else begin
			if (toggle_pwm) pwm_en <= ~pwm_en;
			if (toggle_chip) chip_en <= ~chip_en;
		end
	end
endmodule : pwm_ctrl_model

// >>> tb/lvbus_fault_resp_test.sv
// Self-checking bench for the low-voltage bus fault response block
`define CHK(nm, exp, got) \
	comparisons++; \
	if ((got) !== (exp)) begin \
		bad_count++; \
		$display("FAIL %s expected %h seen %h", nm, exp, got); \
	end

module lvbus_fault_resp_test;
	timeunit 1ns;
	timeprecision 1ns;
	import fault_resp_pkg::*;
	localparam int HC = 20;
	logic clk = 0, resetn = 0, hsel = 0, hwrite = 0, tg_pwm = 0, tg_chip = 0;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, rdv;
	logic [1:0] htrans = 0, mode_strap = 0;
	logic [2:0] hsize = 0, det = 0;
	logic hreadyout, hresp, pwm_en, chip_en, fault_flag_n, pwm_stop, irq;
	int bad_count = 0, comparisons = 0, cycles = 0;

	always #5 clk = ~clk;

	lvbus_fault_resp #(.HICCUP_CYCLES(HC)) dut (.clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .out_ov_det(det[0]), .out_uv_det(det[1]),
		.in_ov_det(det[2]), .pwm_en(pwm_en), .chip_en(chip_en), .mode_strap(mode_strap),
		.fault_flag_n(fault_flag_n), .pwm_stop(pwm_stop), .irq(irq));

	pwm_ctrl_model partner (.clk(clk), .resetn(resetn), .toggle_pwm(tg_pwm), .toggle_chip(tg_chip),
		.pwm_en(pwm_en), .chip_en(chip_en));

	// Single word transfer; read data lands in rdv
	task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {22'h0, idx, 2'h0};
		hwrite <= wr;
		hsize <= HSIZE_WORD;
		do @(posedge clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= wd;
		do @(posedge clk); while (hreadyout !== 1'b1);
		rdv = hrdata;
	endtask : bus

	// Ask the partner for two flips of one enable pin
	task automatic rearm(input logic use_chip);
		@(posedge clk);
		tg_pwm <= !use_chip;
		tg_chip <= use_chip;
		repeat (2) @(posedge clk);
		tg_pwm <= 1'b0;
		tg_chip <= 1'b0;
	endtask : rearm

	task automatic t_reset;
		`CHK("idle flag", 1'b1, fault_flag_n)
		`CHK("idle stop", 1'b0, pwm_stop)
		`CHK("idle irq", 1'b0, irq)
		`CHK("okay resp", 1'b0, hresp)
		bus(1'b0, IDX_STATE, 32'h0);
		`CHK("idle state", 32'h0, rdv)
		bus(1'b0, IDX_RESP, 32'h0);
		`CHK("resp reset", 32'h0, rdv)
		bus(1'b1, IDX_RESP, 32'hff);
		bus(1'b0, IDX_RESP, 32'h0);
		`CHK("resp rw", 32'hff, rdv)
		bus(1'b1, IDX_GLOBAL, 32'hff);
		bus(1'b0, IDX_GLOBAL, 32'h0);
		`CHK("override rw", 32'h80, rdv)
		bus(1'b1, 8'h10, 32'hff);
		bus(1'b0, 8'h10, 32'h0);
		`CHK("unmapped", 32'h0, rdv)
	endtask : t_reset

	// One fault pulse on channel ch with field code and strapped mode
	task automatic run_fault(input int ch, input logic [1:0] code, input logic [1:0] strap, input logic ovr);
		logic [1:0] eff;
		logic stops;
		eff = ovr ? code : strap;
		stops = (eff == RESP_HICCUP) || (eff == RESP_LATCH);
		bus(1'b1, IDX_GLOBAL, {24'h0, ovr, 7'h0});
		bus(1'b1, IDX_RESP, {30'h0, code} << (2 * ch));
		mode_strap <= strap;
		det[ch] <= 1'b1;
		repeat (8) @(posedge clk);
		`CHK("stop on fault", stops, pwm_stop)
		`CHK("flag low", 1'b0, fault_flag_n)
		det[ch] <= 1'b0;
		repeat (12) @(posedge clk);
		`CHK("stop held", stops, pwm_stop)
		repeat (18) @(posedge clk);
		`CHK("auto restart", eff == RESP_LATCH, pwm_stop)
		bus(1'b0, IDX_STATUS, 32'h0);
		`CHK("status bit", 32'h1 << ch, rdv)
		rearm(ch == 2);
		repeat (6) @(posedge clk);
		`CHK("rearmed", 1'b0, pwm_stop)
		bus(1'b1, IDX_STATUS, 32'h7);
		repeat (2) @(posedge clk);
		`CHK("flag released", 1'b1, fault_flag_n)
	endtask : run_fault

	task automatic t_irq;
		bus(1'b1, IDX_RESP, 32'h0);
		bus(1'b1, IDX_MASK, 32'h2);
		bus(1'b0, IDX_MASK, 32'h0);
		`CHK("mask rw", 32'h2, rdv)
		det <= 3'b001;
		repeat (8) @(posedge clk);
		`CHK("irq masked", 1'b0, irq)
		det <= 3'b011;
		repeat (8) @(posedge clk);
		`CHK("irq raised", 1'b1, irq)
		det <= 3'b000;
		repeat (4) @(posedge clk);
		bus(1'b1, IDX_STATUS, 32'h2);
		repeat (2) @(posedge clk);
		`CHK("irq cleared", 1'b0, irq)
		bus(1'b1, IDX_STATUS, 32'h7);
	endtask : t_irq

	// Fault returns mid-count, so the hiccup wait starts over
	task automatic t_retrigger;
		bus(1'b1, IDX_GLOBAL, 32'h80);
		bus(1'b1, IDX_RESP, 32'h4);
		det[1] <= 1'b1;
		repeat (8) @(posedge clk);
		det[1] <= 1'b0;
		repeat (12) @(posedge clk);
		det[1] <= 1'b1;
		repeat (4) @(posedge clk);
		det[1] <= 1'b0;
		repeat (15) @(posedge clk);
		`CHK("count restarts", 1'b1, pwm_stop)
		bus(1'b0, IDX_STATE, 32'h0);
		`CHK("state in hiccup", 32'ha, rdv)
		repeat (15) @(posedge clk);
		`CHK("late restart", 1'b0, pwm_stop)
	endtask : t_retrigger

	task automatic report_and_stop;
		$display("Checks %0d, mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : report_and_stop

	// Hang guard
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 10000) begin
			bad_count++;
			report_and_stop;
		end
	end

	// Main sequence: every code under both override settings on every channel
	initial begin
		repeat (5) @(posedge clk);
		resetn <= 1'b1;
		repeat (3) @(posedge clk);
		t_reset;
		for (int ch = 0; ch < 3; ch++) begin
			for (int c = 0; c < 4; c++) begin
				run_fault(ch, 2'(c), (c == 1) ? RESP_LATCH : RESP_HICCUP, 1'b1);
				run_fault(ch, (c == 1) ? RESP_LATCH : RESP_HICCUP, 2'(c), 1'b0);
			end
		end
		t_irq;
		t_retrigger;
		report_and_stop;
	end
endmodule : lvbus_fault_resp_test
